/* File: hw/adc_sequence_result_control.sv */
// Sequence controller: result placement, justification, length and freeze.
// Assumes the converter core shares clk and pulses conv_done with its data.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module adc_sequence_result_control #(
  parameter int DATA_W = adc_seq_pkg::DATA_W
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              conv_done,
  input  wire logic [DATA_W-1:0] conv_data,
  input  wire logic              ext_trigger,
  input  wire logic              breakpoint,
  output logic                   conv_start,
  output logic                   conv_abort,
  output logic                   conv_freeze,
  output logic                   seq_active,
  output logic                   compare_irq_gate,
  output logic      [5:0]        compare_en_eff
);

  // A full 16-bit result would leave no room for the left-justify padding.
  if (DATA_W < 1 || DATA_W > 15) begin : g_bad_width
    $error("DATA_W must lie between 1 and 15");
  end

  localparam int N = adc_seq_pkg::NUM_RESULTS;

  logic [7:0]            ctl2_r;
  adc_seq_pkg::ctl3_t    ctl3_r;
  logic [7:0]            ctl5_r;
  logic [5:0]            cmp_en_r;
  logic [N-1:0]          flags_r;
  logic [15:0]           res_r [N];
  logic                  pready_r;
  logic                  pslverr_r;
  logic [31:0]           prdata_r;
  logic                  armed_r;
  logic                  restart_r;
  logic [2:0]            count_r;
  logic [3:0]            pos_r;
  adc_seq_pkg::seq_state_t state_r;
  adc_seq_pkg::seq_state_t state_nxt;
  logic                  conv_start_r;
  logic                  conv_abort_r;
  logic                  conv_freeze_r;
  logic                  seq_active_r;
  logic                  irq_gate_r;
  logic [5:0]            cmp_en_eff_r;
  logic [31:0]           rd_val;
  logic                  rd_hit;

  // Bus decode; writes and read side effects act at the completing edge.
  logic       access, done_x, wr, rd;
  logic [5:0] idx;
  logic [5:0] res_off;
  logic       res_hit;
  logic [2:0] res_sel;
  assign access  = psel & penable;
  assign done_x  = access & pready_r;
  assign wr      = done_x & pwrite;
  assign rd      = done_x & ~pwrite;
  assign idx     = paddr[7:2];
  assign res_off = idx - adc_seq_pkg::IDX_RESULT0;
  assign res_hit = (idx >= adc_seq_pkg::IDX_RESULT0) && (res_off < 6'(N));
  assign res_sel = res_off[2:0];

  logic wr_ctl2, wr_ctl3, wr_ctl5;
  assign wr_ctl2 = wr && idx == adc_seq_pkg::IDX_CTL2;
  assign wr_ctl3 = wr && idx == adc_seq_pkg::IDX_CTL3;
  assign wr_ctl5 = wr && idx == adc_seq_pkg::IDX_CTL5;

  // Sequence events.
  logic fifo, ext_trig_en, scan_on, abort, start_seq;
  logic store, last, bp_now, bp_finish;
  assign fifo        = ctl3_r.fifo_mode;
  assign ext_trig_en = ctl2_r[adc_seq_pkg::CTL2_EXT_TRIG_BIT];
  assign scan_on = ctl5_r[adc_seq_pkg::CTL5_SCAN_BIT] & ~ext_trig_en;
  assign abort = wr_ctl2 | wr_ctl3;
  // Start register restarts; an armed trigger starts from idle.
  assign start_seq = ~abort & (wr_ctl5 | (ext_trigger & ext_trig_en &
                     armed_r & state_r == adc_seq_pkg::ST_IDLE));
  assign store = conv_done & state_r == adc_seq_pkg::ST_BUSY & ~abort &
                 ~start_seq;
  assign last = count_r == adc_seq_pkg::seq_count_f(ctl3_r.seq_len) - 3'h1;
  assign bp_now    = breakpoint &
                     ctl3_r.breakpoint_response == adc_seq_pkg::BRK_NOW;
  assign bp_finish = breakpoint &
                     ctl3_r.breakpoint_response == adc_seq_pkg::BRK_FINISH;

  // Next sequencer state; abort takes precedence over any start.
  always_comb begin
    state_nxt = state_r;
    if (abort) begin
      state_nxt = adc_seq_pkg::ST_IDLE;
    end else if (start_seq) begin
      state_nxt = adc_seq_pkg::ST_BUSY;
    end else begin
      case (state_r)
        adc_seq_pkg::ST_BUSY: begin
          if (conv_done && last && !scan_on) begin
            state_nxt = adc_seq_pkg::ST_IDLE;
          end else if ((conv_done && bp_finish) || (!conv_done && bp_now)) begin
            state_nxt = adc_seq_pkg::ST_FROZEN;
          end
        end
        adc_seq_pkg::ST_FROZEN: begin
          if (!breakpoint) begin
            state_nxt = adc_seq_pkg::ST_BUSY;
          end
        end
        default:              state_nxt = adc_seq_pkg::ST_IDLE;
      endcase
    end
  end

  // Sequencer state and converter strobes.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r       <= adc_seq_pkg::ST_IDLE;
      restart_r     <= 1'b0;
      conv_start_r  <= 1'b0;
      conv_abort_r  <= 1'b0;
      conv_freeze_r <= 1'b0;
      seq_active_r  <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      conv_abort_r <= abort;
      seq_active_r <= state_nxt != adc_seq_pkg::ST_IDLE;
      // A finish-then-freeze stop needs a fresh start on resume; an
      // immediate freeze only holds the core, which then carries on.
      if (state_r == adc_seq_pkg::ST_BUSY &&
          state_nxt == adc_seq_pkg::ST_FROZEN) begin
        restart_r <= conv_done;
      end
      conv_freeze_r <= state_nxt == adc_seq_pkg::ST_FROZEN;
      conv_start_r  <= start_seq |
        (store && state_nxt == adc_seq_pkg::ST_BUSY) |
        (state_r == adc_seq_pkg::ST_FROZEN &&
         state_nxt == adc_seq_pkg::ST_BUSY && restart_r);
    end
  end

  // Conversion count and result position counter.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_r <= 3'h0;
      pos_r   <= 4'h0;
    end else if (abort || start_seq) begin
      count_r <= 3'h0;
      pos_r   <= 4'h0;
    end else if (store) begin
      count_r <= last ? 3'h0 : count_r + 3'h1;
      if (fifo) begin
        pos_r <= (pos_r == adc_seq_pkg::POS_LAST) ? 4'h0 : pos_r + 4'h1;
      end else begin
        pos_r <= last ? 4'h0 : pos_r + 4'h1;
      end
    end
  end

  logic [15:0] fmt_val;
  assign fmt_val = ctl3_r.justify_right ? 16'(conv_data) :
                   {conv_data, {(16 - DATA_W){1'b0}}};

  // Compare enables seen by the compare logic.
  logic [5:0] cmp_en_eff;
  assign cmp_en_eff = cmp_en_r & {6{~fifo}};

  // Result registers and complete flags, one slot per entry.
  for (genvar i = 0; i < N; i++) begin : g_slot
    logic set_i;
    logic clr_i;
    assign set_i = store && pos_r == 4'(i);
    // Fast clear on read or write.
    assign clr_i = (wr && idx == adc_seq_pkg::IDX_FLAGS && pwdata[i]) |
                   (ctl2_r[adc_seq_pkg::CTL2_FFC_BIT] && res_hit &&
                    res_sel == 3'(i) && (cmp_en_eff[i] ? wr : rd));
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        res_r[i]   <= 16'h0000;
        flags_r[i] <= 1'b0;
      end else begin
        if (set_i) begin
          res_r[i] <= fmt_val;
        end
        // A completing conversion wins over a clear in the same cycle.
        flags_r[i] <= set_i | (flags_r[i] & ~clr_i);
      end
    end
  end

  // Software registers.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl2_r  <= adc_seq_pkg::CTL2_RESET;
      ctl3_r  <= adc_seq_pkg::CTL3_RESET;
      ctl5_r  <= adc_seq_pkg::CTL5_RESET;
      cmp_en_r <= 6'h00;
      armed_r <= 1'b0;
    end else begin
      if (wr_ctl2) begin
        ctl2_r <= pwdata[7:0];
      end
      if (wr_ctl3) begin
        ctl3_r <= adc_seq_pkg::ctl3_t'(pwdata[7:0]);
      end
      if (wr_ctl5) begin
        ctl5_r  <= pwdata[7:0];
        armed_r <= 1'b1;
      end
      if (wr && idx == adc_seq_pkg::IDX_CMP_EN) begin
        cmp_en_r <= pwdata[5:0];
      end
    end
  end

  // Read multiplexer.
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    if (res_hit) begin
      rd_val = {16'h0000, res_r[res_sel]};
    end else begin
      case (idx)
        adc_seq_pkg::IDX_CTL2:  rd_val[7:0] = ctl2_r;
        adc_seq_pkg::IDX_CTL3:  rd_val[7:0] = ctl3_r;
        adc_seq_pkg::IDX_CTL5:  rd_val[7:0] = ctl5_r;
        adc_seq_pkg::IDX_CMP_EN: rd_val[5:0] = cmp_en_r;
        adc_seq_pkg::IDX_FLAGS: rd_val[N-1:0] = flags_r;
        adc_seq_pkg::IDX_STATUS: begin
          rd_val[3:0] = pos_r;
          rd_val[adc_seq_pkg::STAT_BUSY_BIT] =
            state_r != adc_seq_pkg::ST_IDLE;
          rd_val[adc_seq_pkg::STAT_FROZEN_BIT] =
            state_r == adc_seq_pkg::ST_FROZEN;
        end
        default: rd_hit = 1'b0;
      endcase
    end
  end

  // APB answer: one wait state, data and error registered with pready.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      irq_gate_r <= 1'b0;
      cmp_en_eff_r <= 6'h00;
    end else begin
      pready_r  <= access & ~pready_r;
      pslverr_r <= access & ~pready_r & ~rd_hit;
      if (access && !pready_r && !pwrite) begin
        prdata_r <= rd_hit ? rd_val : 32'h0000_0000;
      end
      irq_gate_r <= ctl2_r[adc_seq_pkg::CTL2_CMP_IRQ_BIT] & ~fifo;
      cmp_en_eff_r <= cmp_en_eff;
    end
  end

  assign prdata           = prdata_r;
  assign pready           = pready_r;
  assign pslverr          = pslverr_r;
  assign conv_start       = conv_start_r;
  assign conv_abort       = conv_abort_r;
  assign conv_freeze      = conv_freeze_r;
  assign seq_active       = seq_active_r;
  assign compare_irq_gate = irq_gate_r;
  assign compare_en_eff   = cmp_en_eff_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  abort_to_idle_a: assert property (wr_ctl3 |=>
    state_r == adc_seq_pkg::ST_IDLE && pos_r == 4'h0 && conv_abort_r)
    else $error("control write did not abort");
  justify_store_a: assert property (store |=>
    res_r[$past(res_sel) & 3'h0 | 3'($past(pos_r))] ==
    ($past(ctl3_r.justify_right) ? 16'($past(conv_data)) :
     {$past(conv_data), {(16 - DATA_W){1'b0}}}))
    else $error("stored result badly justified");
  len_bound_a: assert property (state_r != adc_seq_pkg::ST_IDLE |->
    count_r < adc_seq_pkg::seq_count_f(ctl3_r.seq_len))
    else $error("conversion count beyond sequence length");
  len_reset_a: assert property ($rose(rst_b) |->
    ctl3_r.seq_len == 4'h4) else $error("length not four after reset");
  fixed_pos_a: assert property (!fifo |-> 4'(count_r) == pos_r)
    else $error("fixed mode position differs from count");
  fifo_wrap_a: assert property (store && fifo |=>
    pos_r == (($past(pos_r) == 4'h5) ? 4'h0 : $past(pos_r) + 4'h1))
    else $error("FIFO position did not advance or wrap");
  status_pos_a: assert property (access && !pready_r && !pwrite &&
    idx == adc_seq_pkg::IDX_STATUS |=> prdata_r[3:0] == $past(pos_r))
    else $error("status shows wrong position");
  start_clear_a: assert property (wr_ctl5 |=>
    pos_r == 4'h0 && state_r == adc_seq_pkg::ST_BUSY && conv_start_r)
    else $error("start did not restart at position zero");
  compare_off_a: assert property (fifo |=>
    compare_en_eff == 6'h00 && !compare_irq_gate)
    else $error("compare active in FIFO mode");
  freeze_now_a: assert property (state_r == adc_seq_pkg::ST_BUSY &&
    bp_now && !conv_done && !abort && !start_seq |=>
    state_r == adc_seq_pkg::ST_FROZEN && conv_freeze)
    else $error("immediate freeze not taken");
  rsvd_runs_a: assert property (!ctl3_r.breakpoint_response[1] |->
    state_r != adc_seq_pkg::ST_FROZEN) else $error("froze with code 0x");
  scan_end_a: assert property (store && last && !scan_on |=>
    state_r == adc_seq_pkg::ST_IDLE) else $error("single sequence ran on");

  fifo_wrap_c: cover property (store && fifo && pos_r == 4'h5);
  frozen_c:    cover property (state_r == adc_seq_pkg::ST_FROZEN ##1
                               state_r == adc_seq_pkg::ST_BUSY);
  scan_c:      cover property (store && last && scan_on);

endmodule : adc_sequence_result_control
`default_nettype wire

/* File: hw/adc_seq_pkg.sv */
// Constants, types and helpers of the converter sequence and result control.
// Assumes an APB slave on a 50 MHz clock with word-aligned register slots.
package adc_seq_pkg;

  localparam int NUM_RESULTS = 6;
  localparam int DATA_W      = 10;

  // Register indices; byte address is four times the index.
  localparam logic [5:0] IDX_CTL2    = 6'h02;
  localparam logic [5:0] IDX_CTL3    = 6'h03;
  localparam logic [5:0] IDX_CTL5    = 6'h05;
  localparam logic [5:0] IDX_STATUS  = 6'h06;
  localparam logic [5:0] IDX_CMP_EN  = 6'h07;
  localparam logic [5:0] IDX_FLAGS   = 6'h08;
  localparam logic [5:0] IDX_RESULT0 = 6'h10;

  localparam logic [7:0] CTL2_RESET = 8'h00;
  localparam logic [7:0] CTL3_RESET = 8'h20;
  localparam logic [7:0] CTL5_RESET = 8'h00;

  localparam int CTL2_FFC_BIT    = 6;
  localparam int CTL2_EXT_TRIG_BIT = 2;
  localparam int CTL2_CMP_IRQ_BIT  = 0;
  localparam int CTL5_SCAN_BIT   = 5;
  localparam int STAT_BUSY_BIT   = 7;
  localparam int STAT_FROZEN_BIT = 6;

  localparam logic [1:0] BRK_CONT   = 2'h0;
  localparam logic [1:0] BRK_RSVD   = 2'h1;
  localparam logic [1:0] BRK_FINISH = 2'h2;
  localparam logic [1:0] BRK_NOW    = 2'h3;

  localparam logic [3:0] POS_LAST = 4'h5;

  // Field layout of the result format and sequence control register.
  typedef struct packed {
    logic       justify_right;
    logic [3:0] seq_len;
    logic       fifo_mode;
    logic [1:0] breakpoint_response;
  } ctl3_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_BUSY   = 3'b010,
    ST_FROZEN = 3'b100
  } seq_state_t;

  // Conversions per sequence for a length code.
  function automatic logic [2:0] seq_count_f(input logic [3:0] code);
    seq_count_f = 3'h6;
    if (code >= 4'h1 && code <= 4'h5) begin
      seq_count_f = code[2:0];
    end
  endfunction : seq_count_f

endpackage : adc_seq_pkg

/* File: test/adc_seq_tb.sv */
// Self-checking bench for the converter sequence and result control block.
// Assumes the block answers APB with one wait state and shares one clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk         = 1'b0;
  logic        rst_b       = 1'b0;
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [7:0]  paddr       = 8'h00;
  logic [31:0] pwdata      = 32'h0000_0000;
  logic        conv_done   = 1'b0;
  logic [9:0]  conv_data   = 10'h000;
  logic        ext_trigger = 1'b0;
  logic        breakpoint  = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        conv_start;
  logic        conv_abort;
  logic        conv_freeze;
  logic        seq_active;
  logic        compare_irq_gate;
  logic [5:0]  compare_en_eff;
  logic [31:0] rd;
  logic        err;
  int          fail_count  = 0;
  int          compares    = 0;
  int          starts      = 0;
  int          used        = 0;
  int          aborts      = 0;
  int          cnt;
  // Each row: control value written, conversions per sequence it gives.
  logic [7:0]  row_cfg [16] = '{8'h00, 8'h89, 8'h12, 8'h9B, 8'h20, 8'hA9,
    8'h32, 8'hBB, 8'h40, 8'hC9, 8'h52, 8'hDB, 8'h60, 8'hE9, 8'h72, 8'hFB};
  int          row_cnt [16] = '{6, 1, 2, 3, 4, 5, 6, 6, 6, 6, 6, 6, 6, 6, 6, 6};

  adc_sequence_result_control u_dut (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_done(conv_done),
    .conv_data(conv_data), .ext_trigger(ext_trigger),
    .breakpoint(breakpoint), .conv_start(conv_start),
    .conv_abort(conv_abort), .conv_freeze(conv_freeze),
    .seq_active(seq_active), .compare_irq_gate(compare_irq_gate),
    .compare_en_eff(compare_en_eff)
  );

  // Free-running 50 MHz clock.
  always #10 clk = ~clk;

  // Pulse counters update late on purpose, so the sequence never races them.
  always @(posedge clk) begin
    if (conv_start === 1'b1)
      starts <= starts + 1;
    if (conv_abort === 1'b1)
      aborts <= aborts + 1;
  end

  task automatic end_sim();
    if (fail_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; returns just after an edge with the bus idle.
  task automatic apb(input logic w, input logic [5:0] idx,
                     input logic [31:0] wd);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  function automatic logic [9:0] dval(input int k);
    dval = 10'h2A0 + 10'(k);
  endfunction : dval

  // Unsigned result as stored: left keeps the top bits, right is zero-extended.
  function automatic logic [31:0] just(input logic j, input logic [9:0] d);
    just = j ? {22'h0, d} : {16'h0, d, 6'h00};
  endfunction : just

  task automatic start_seq(input logic [31:0] v);
    used = starts;
    apb(1'b1, 6'h05, v);
  endtask : start_seq

  task automatic wait_start();
    int n;
    n = 0;
    while (starts == used && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) begin
      fail_count++;
      end_sim();
    end
    used++;
  endtask : wait_start

  task automatic pulse(input int k);
    conv_data <= dval(k);
    conv_done <= 1'b1;
    @(posedge clk);
    conv_done <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : pulse

  // Answers every conversion start until the sequence goes idle.
  task automatic run_seq();
    cnt = 0;
    repeat (2) @(posedge clk);
    while (seq_active === 1'b1 && cnt < 8) begin
      wait_start();
      pulse(cnt);
      cnt++;
    end
  endtask : run_seq

  // Main sequence: reset, table of lengths, then the awkward cases.
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    apb(1'b0, 6'h03, 32'h0000_0000);
    check(rd, 32'h0000_0020);
    apb(1'b1, 6'h04, 32'h0000_00FF);
    check(err, 1'b1);
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, 6'h03, {24'h00_0000, row_cfg[i]});
      apb(1'b0, 6'h03, 32'h0000_0000);
      check(rd, {24'h00_0000, row_cfg[i]});
      start_seq(32'h0000_0000);
      run_seq();
      check(cnt, row_cnt[i]);
      for (int k = 0; k < row_cnt[i]; k++) begin
        apb(1'b0, 6'h10 + k[5:0], 32'h0000_0000);
        check(rd, just(row_cfg[i][7], dval(k)));
      end
    end
    apb(1'b1, 6'h03, 32'h0000_0020);
    start_seq(32'h0000_0000);
    wait_start();
    cnt = aborts;
    apb(1'b1, 6'h03, 32'h0000_0020);
    repeat (2) @(posedge clk);
    check(aborts - cnt, 1);
    check(seq_active, 1'b0);
    apb(1'b1, 6'h03, 32'h0000_0024);
    start_seq(32'h0000_0020);
    for (int k = 0; k < 8; k++) begin
      wait_start();
      pulse(k);
      apb(1'b0, 6'h06, 32'h0000_0000);
      check(rd & 32'h0000_000F, (k + 1) % 6);
    end
    for (int r = 0; r < 6; r++) begin
      apb(1'b0, 6'h10 + r[5:0], 32'h0000_0000);
      check(rd, just(1'b0, dval(r < 2 ? r + 6 : r)));
    end
    start_seq(32'h0000_0000);
    apb(1'b0, 6'h06, 32'h0000_0000);
    check(rd & 32'h0000_000F, 0);
    wait_start();
    pulse(9);
    apb(1'b0, 6'h10, 32'h0000_0000);
    check(rd, just(1'b0, dval(9)));
    apb(1'b1, 6'h02, 32'h0000_0001);
    apb(1'b1, 6'h07, 32'h0000_003F);
    for (int f = 0; f < 2; f++) begin
      apb(1'b1, 6'h03, 32'h0000_0020 | 32'(f << 2));
      repeat (2) @(posedge clk);
      check({compare_irq_gate, compare_en_eff}, f ? 7'h00 : 7'h7F);
    end
    // complete flags tracked, fast clear by read or by write
    apb(1'b1, 6'h02, 32'h0000_0040);
    apb(1'b1, 6'h08, 32'h0000_003F);
    for (int c = 1; c >= 0; c--) begin
      apb(1'b1, 6'h07, 32'(c));
      apb(1'b1, 6'h03, 32'h0000_0008);
      start_seq(32'h0000_0000);
      run_seq();
      apb(1'b0, 6'h10, 32'h0000_0000);
      apb(1'b0, 6'h08, 32'h0000_0000);
      check(rd, 32'(c));
      apb(1'b1, 6'h10, 32'h0000_0000);
      apb(1'b0, 6'h08, 32'h0000_0000);
      check(rd, 32'h0000_0000);
    end
    for (int f = 0; f < 4; f++) begin
      apb(1'b1, 6'h03, 32'h0000_0010 | 32'(f));
      start_seq(32'h0000_0000);
      wait_start();
      breakpoint <= 1'b1;
      repeat (3) @(posedge clk);
      check(conv_freeze, f == 3);
      apb(1'b0, 6'h06, 32'h0000_0000);
      check(rd[7:6], f == 3 ? 2'h3 : 2'h2);
      pulse(0);
      check(conv_freeze, f >= 2);
      breakpoint <= 1'b0;
      repeat (3) @(posedge clk);
      check(conv_freeze, 1'b0);
    end
    // scan ignored under external trigger; an armed trigger restarts
    apb(1'b1, 6'h02, 32'h0000_0004);
    apb(1'b1, 6'h03, 32'h0000_0008);
    start_seq(32'h0000_0020);
    run_seq();
    check(cnt, 1);
    ext_trigger <= 1'b1;
    @(posedge clk);
    ext_trigger <= 1'b0;
    repeat (2) @(posedge clk);
    check(seq_active, 1'b1);
    // second reset in mid-sequence restores the length
    start_seq(32'h0000_0000);
    rst_b <= 1'b0;
    @(posedge clk);
    check(seq_active, 1'b0);
    rst_b <= 1'b1;
    @(posedge clk);
    apb(1'b0, 6'h03, 32'h0000_0000);
    check(rd, 32'h0000_0020);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
